// ==== core/sfd_pkg.sv ====
// constants, register map and fault numbering for the servo fault detector
package sfd_pkg;
    localparam int CLK_MHZ        = 200;
    localparam int ENC_TIMEOUT_US = 1000;
    localparam int ENC_TIMEOUT_CYC = ENC_TIMEOUT_US * CLK_MHZ;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_SHIELD  = 8'h04;
    localparam logic [7:0] OFS_THRESH  = 8'h08;
    localparam logic [7:0] OFS_LINK_WR = 8'h0C;
    localparam logic [7:0] OFS_STATUS  = 8'h10;
    localparam logic [7:0] OFS_INTMASK = 8'h14;
    localparam logic [7:0] OFS_CODE    = 8'h18;
    localparam logic [7:0] OFS_ENC_RES = 8'h1C;
    localparam logic [7:0] OFS_Z_POS   = 8'h20;

    // control and shield bits
    localparam int CTRL_WATCH      = 0;
    localparam int CTRL_LEARN_WIND = 1;
    localparam int CTRL_LEARN_ENC  = 2;
    localparam int CTRL_WIND_NEG   = 3;
    localparam int SHIELD_PHASE    = 2;
    localparam int SHIELD_DI       = 3;

    // reset values
    localparam logic [15:0] THRESH_RST  = 16'h0FA0;
    localparam logic [15:0] ENC_RES_RST = 16'h1000;

    // status bit positions
    localparam int NFAULT  = 11;
    localparam int F_CUR   = 0;
    localparam int F_ENC   = 1;
    localparam int F_NVM   = 2;
    localparam int F_PHASE = 3;
    localparam int F_LINK  = 4;
    localparam int F_DI    = 5;
    localparam int F_WIND  = 6;
    localparam int F_NOZ   = 7;
    localparam int F_ZOFS  = 8;
    localparam int F_HALL  = 9;
    localparam int F_HOT   = 10;

    // fault codes 104..117, indexed by status bit
    localparam logic [NFAULT-1:0][7:0] FAULT_CODES = {8'h75, 8'h73, 8'h72, 8'h71, 8'h6F, 8'h6D,
                                                      8'h6C, 8'h6B, 8'h6A, 8'h69, 8'h68};

    typedef enum logic [2:0] {
        SFD_IDLE = 3'b001,
        SFD_SEEK = 3'b010,
        SFD_DONE = 3'b100
    } sfd_learn_t;

    // code of the lowest-numbered pending event, zero when none
    function automatic logic [7:0] sfd_code(input logic [NFAULT-1:0] ev);
        logic [7:0] c;
        c = 8'h00;
        for (int i = NFAULT - 1; i >= 0; i--)
            if (ev[i])
                c = FAULT_CODES[i];
        return c;
    endfunction
endpackage

// ==== core/sfd_sync.sv ====
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module sfd_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,  // system clock
    input  wire logic         rst_n,    // synchronised reset
    input  wire logic         ce,       // clock enable
    input  wire logic [W-1:0] d,        // asynchronous input
    output logic      [W-1:0] q         // synchronised output
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sfd_sync_t;

    sfd_sync_t r;
    sfd_sync_t n;

    always_comb
    begin
        n = r;
        if (ce)
        begin
            n.s1 = d;
            n.s2 = r.s1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            r <= '0;
        else
            r <= n;
    end

    assign q = r.s2;
endmodule

// ==== core/sfd_quad.sv ====
// quadrature decoder with illegal-transition and loss-of-signal watch
`timescale 1ns/1ps
module sfd_quad #(
    parameter int unsigned TIMEOUT = 1000
) (
    input  wire logic sys_clk,   // system clock
    input  wire logic rst_n,     // synchronised reset
    input  wire logic ce,        // clock enable
    input  wire logic a,         // synchronised channel a
    input  wire logic b,         // synchronised channel b
    input  wire logic watch_en,  // enables the loss-of-signal watch
    output logic      step,      // one count moved
    output logic      dir_neg,   // direction of the last step
    output logic      illegal,   // both channels changed at once
    output logic      timeout    // no edge within the watch time
);
    typedef struct packed {
        logic [1:0]  ab;
        logic [31:0] wd;
        logic        step;
        logic        dir_neg;
        logic        illegal;
        logic        timeout;
    } sfd_quad_t;

    sfd_quad_t r;
    sfd_quad_t n;
    logic [3:0] tr;

    always_comb
    begin
        n  = r;
        tr = {r.ab, a, b};
        if (ce)
        begin
            n.ab      = {a, b};
            n.step    = 1'b0;
            n.illegal = 1'b0;
            n.timeout = 1'b0;
            case (tr)
                4'h1, 4'h7, 4'hE, 4'h8:
                begin
                    n.step    = 1'b1;
                    n.dir_neg = 1'b0;
                end
                4'h2, 4'hB, 4'hD, 4'h4:
                begin
                    n.step    = 1'b1;
                    n.dir_neg = 1'b1;
                end
                4'h3, 4'hC, 4'h6, 4'h9:
                    n.illegal = 1'b1;
                default:
                    n.step = 1'b0;
            endcase
            // any edge, legal or not, proves the cable is alive
            if (!watch_en || r.ab != {a, b})
                n.wd = 32'h00000000;
            else if (r.wd == 32'(TIMEOUT - 1))
            begin
                n.wd      = 32'h00000000;
                n.timeout = 1'b1;
            end
            else
                n.wd = r.wd + 32'h00000001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            r <= '0;
        else
            r <= n;
    end

    assign step    = r.step;
    assign dir_neg = r.dir_neg;
    assign illegal = r.illegal;
    assign timeout = r.timeout;
endmodule

// ==== core/sfd_top.sv ====
// servo fault detector: fault checks, fault latch and apb register file
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module sfd_top
    import sfd_pkg::*;
#(
    parameter int unsigned ENC_TIMEOUT = ENC_TIMEOUT_CYC
) (
    input  wire logic        sys_clk,                 // 200 MHz system clock
    input  wire logic        resetn,                  // asynchronous reset, active low
    input  wire logic        ce,                      // clock enable, freezes all state except the reset synchroniser
    input  wire logic [7:0]  paddr,                   // apb address
    input  wire logic        psel,                    // apb select
    input  wire logic        penable,                 // apb enable
    input  wire logic        pwrite,                  // apb direction
    input  wire logic [31:0] pwdata,                  // apb write data
    output logic      [31:0] prdata,                  // apb read data
    output logic             pready,                  // apb ready
    output logic             pslverr,                 // apb error, unmapped address
    input  wire logic [2:0]  hall_in,                 // hall switch pins
    input  wire logic        enc_a_in,                // encoder channel a pin
    input  wire logic        enc_b_in,                // encoder channel b pin
    input  wire logic        enc_z_in,                // encoder index pin
    input  wire logic        cur_sensor_fail,         // current sensing path failed
    input  wire logic [15:0] cur_sample,              // signed current sample
    input  wire logic        cur_valid,               // cur_sample is new
    input  wire logic        nvm_rd_done,             // parameter memory read finished
    input  wire logic        nvm_rd_err,              // that read returned an error
    input  wire logic [31:0] pl_echo,                 // value read back from the logic side
    input  wire logic        pl_echo_valid,           // pl_echo is new
    input  wire logic [2:0]  enc_sector,              // encoder-derived rotor sector 0..5
    input  wire logic [15:0] drive_temperature_value, // measured drive temperature
    output logic             irq,                     // level interrupt
    output logic      [7:0]  fault_code_out,          // latched fault code
    output logic             fault_active             // a fault code is latched
);
    ////////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers
    logic [1:0] rst_sync;
    logic       rst_n;
    logic [5:0] pins_s;
    logic [2:0] hall;
    logic       enc_a;
    logic       enc_b;
    logic       enc_z;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    sfd_sync #(.W(6)) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .d       ({hall_in, enc_a_in, enc_b_in, enc_z_in}),
        .q       (pins_s)
    );
    assign {hall, enc_a, enc_b, enc_z} = pins_s;

    ////////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [3:0]        ctrl;
        logic [31:0]       shield;
        logic [15:0]       thresh;
        logic [31:0]       link_wr;
        logic [15:0]       enc_res;
        logic [NFAULT-1:0] status;
        logic [NFAULT-1:0] intmask;
        logic [7:0]        code;
        logic              code_valid;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
        logic              irq;
        logic [15:0]       prev_cur;
        logic              have_prev;
        logic              z_prev;
        sfd_learn_t        st;
        logic [16:0]       steps;
        logic [16:0]       zpos;
    } sfd_state_t;

    sfd_state_t r;
    sfd_state_t n;

    logic              q_step;
    logic              q_dir_neg;
    logic              q_illegal;
    logic              q_timeout;
    logic [NFAULT-1:0] ev;
    logic [NFAULT-1:0] ev_kept;
    logic [15:0]       abs_cur;
    logic [15:0]       abs_prev;
    logic [16:0]       diff;
    logic [2:0]        hsec;
    logic [2:0]        sdist;
    logic              acc;
    logic              wr_done;
    logic              rd_done;

    sfd_quad #(.TIMEOUT(ENC_TIMEOUT)) u_quad (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .a        (enc_a),
        .b        (enc_b),
        .watch_en (r.ctrl[CTRL_WATCH]),
        .step     (q_step),
        .dir_neg  (q_dir_neg),
        .illegal  (q_illegal),
        .timeout  (q_timeout)
    );

    function automatic logic [15:0] mag(input logic [15:0] v);
        return v[15] ? 16'(-v) : v;
    endfunction

    // hall pattern to sector, 3'h7 for the two forbidden codes
    function automatic logic [2:0] hall_sector(input logic [2:0] h);
        case (h)
            3'h1:    return 3'h0;
            3'h3:    return 3'h1;
            3'h2:    return 3'h2;
            3'h6:    return 3'h3;
            3'h4:    return 3'h4;
            3'h5:    return 3'h5;
            default: return 3'h7;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // fault checks and register file
    always_comb
    begin
        n        = r;
        ev       = '0;
        abs_cur  = mag(cur_sample);
        abs_prev = mag(r.prev_cur);
        diff     = {1'b0, mag(16'(cur_sample - r.prev_cur))};
        hsec     = hall_sector(hall);
        sdist    = (hsec >= enc_sector) ? 3'(hsec - enc_sector) : 3'(hsec + 3'h6 - enc_sector);
        acc      = psel && penable && r.pready;
        wr_done  = acc && pwrite;
        rd_done  = acc && !pwrite;

        ev[F_CUR] = cur_sensor_fail;
        ev[F_ENC] = r.ctrl[CTRL_WATCH] && (q_illegal || q_timeout);
        ev[F_NVM] = nvm_rd_done && nvm_rd_err;
        ev[F_PHASE] = r.ctrl[CTRL_WATCH] && hsec != 3'h7 && enc_sector < 3'h6 && sdist >= 3'h2 && sdist <= 3'h4;
        ev[F_LINK] = pl_echo_valid && pl_echo != r.link_wr;
        ev[F_DI] = cur_valid && r.have_prev && abs_prev != 16'h0000 && {diff[15:0], 1'b0} >= {1'b0, abs_prev};
        ev[F_WIND] = r.ctrl[CTRL_LEARN_WIND] && cur_valid && r.have_prev &&
                     (r.ctrl[CTRL_WIND_NEG] ? $signed(cur_sample) > $signed(r.prev_cur)
                                            : $signed(cur_sample) < $signed(r.prev_cur));
        ev[F_HALL] = r.st == SFD_SEEK && (hall == 3'h0 || hall == 3'h7);
        ev[F_HOT] = drive_temperature_value > r.thresh;

        if (cur_valid)
        begin
            n.prev_cur  = cur_sample;
            n.have_prev = 1'b1;
        end
        n.z_prev = enc_z;

        // encoder self-learning: count steps until the index edge
        case (r.st)
            SFD_IDLE:
            begin
                n.steps = 17'h00000;
                if (r.ctrl[CTRL_LEARN_ENC])
                    n.st = SFD_SEEK;
            end
            SFD_SEEK:
            begin
                if (q_step)
                    n.steps = 17'(r.steps + 17'h00001);
                if (!r.ctrl[CTRL_LEARN_ENC])
                    n.st = SFD_IDLE;
                else if (enc_z && !r.z_prev)
                begin
                    n.zpos = r.steps;
                    n.st   = SFD_DONE;
                    ev[F_ZOFS] = r.steps > {1'b0, r.enc_res};
                end
                else if (r.steps > {r.enc_res, 1'b0})
                begin
                    n.st = SFD_DONE;
                    ev[F_NOZ] = 1'b1;
                end
            end
            SFD_DONE:
                if (!r.ctrl[CTRL_LEARN_ENC])
                    n.st = SFD_IDLE;
            default:
                n.st = SFD_IDLE;
        endcase

        // shielded faults dropped before the latch
        ev_kept = ev;
        ev_kept[F_PHASE] = ev[F_PHASE] && !r.shield[SHIELD_PHASE];
        ev_kept[F_DI]    = ev[F_DI] && !r.shield[SHIELD_DI];

        // apb: one wait state, then the handshake edge commits
        n.pready  = psel && penable && !r.pready;
        n.pslverr = 1'b0;
        if (psel && penable && !r.pready)
        begin
            n.prdata = 32'h00000000;
            case (paddr)
                OFS_CTRL:    n.prdata[3:0] = r.ctrl;
                OFS_SHIELD:  n.prdata = r.shield;
                OFS_THRESH:  n.prdata[15:0] = r.thresh;
                OFS_LINK_WR: n.prdata = r.link_wr;
                OFS_STATUS:  n.prdata[NFAULT-1:0] = r.status;
                OFS_INTMASK: n.prdata[NFAULT-1:0] = r.intmask;
                OFS_CODE:    n.prdata[8:0] = {r.code_valid, r.code};
                OFS_ENC_RES: n.prdata[15:0] = r.enc_res;
                OFS_Z_POS:   n.prdata[16:0] = r.zpos;
                default:     n.pslverr = 1'b1;
            endcase
        end
        if (wr_done)
        begin
            case (paddr)
                OFS_CTRL:    n.ctrl = pwdata[3:0];
                OFS_SHIELD:  n.shield = pwdata;
                OFS_THRESH:  n.thresh = pwdata[15:0];
                OFS_LINK_WR: n.link_wr = pwdata;
                OFS_INTMASK: n.intmask = pwdata[NFAULT-1:0];
                OFS_ENC_RES: n.enc_res = pwdata[15:0];
                default:     n.ctrl = r.ctrl;
            endcase
        end

        // sticky latch, read clears only what was returned, set wins
        if (rd_done && paddr == OFS_STATUS)
            n.status = r.status & ~r.prdata[NFAULT-1:0];
        n.status = n.status | ev_kept;
        if (wr_done && paddr == OFS_CODE)
            n.code_valid = 1'b0;
        // first fault holds its code until software clears it
        if (!n.code_valid && ev_kept != '0)
        begin
            n.code       = sfd_code(ev_kept);
            n.code_valid = 1'b1;
        end
        n.irq = (n.status & n.intmask) != '0;

        if (!ce)
            n = r;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r         <= '0;
            r.st      <= SFD_IDLE;
            r.thresh  <= THRESH_RST;
            r.enc_res <= ENC_RES_RST;
        end
        else
            r <= n;
    end

    assign prdata         = r.prdata;
    assign pready         = r.pready;
    assign pslverr        = r.pslverr;
    assign irq            = r.irq;
    assign fault_code_out = r.code;
    assign fault_active   = r.code_valid;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_cur_fail_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && cur_sensor_fail |=> r.status[F_CUR])
        else $error("current sensor fault not latched");

    a_enc_fault_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && r.ctrl[CTRL_WATCH] && (q_illegal || q_timeout) |=> r.status[F_ENC])
        else $error("encoder fault not latched");

    a_nvm_err_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && nvm_rd_done && nvm_rd_err |=> r.status[F_NVM])
        else $error("parameter memory fault not latched");

    a_phase_shield_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && r.shield[SHIELD_PHASE] && !r.status[F_PHASE] |=> !r.status[F_PHASE])
        else $error("shielded phase fault latched");

    a_link_mismatch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && pl_echo_valid && pl_echo != r.link_wr |=> r.status[F_LINK])
        else $error("link mismatch not latched");

    a_di_shield_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && r.shield[SHIELD_DI] && !r.status[F_DI] |=> !r.status[F_DI])
        else $error("shielded current change fault latched");

    a_hall_code_bad: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && r.st == SFD_SEEK && hall == 3'h7 |=> r.status[F_HALL] && r.code_valid)
        else $error("hall code fault not latched");

    a_overheat_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && !r.status[F_HOT] && drive_temperature_value <= r.thresh |=> !r.status[F_HOT])
        else $error("overheat latched at or below threshold");

    a_code_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
        r.code_valid && !(psel && penable && r.pready && pwrite && paddr == OFS_CODE)
        |=> r.code_valid && $stable(r.code))
        else $error("latched fault code changed without clear");
endmodule

// ==== verif/sfd_sensor_model.sv ====
// sensor-side model: quadrature encoder with index line and hall switches
`timescale 1ns/1ps
module sfd_sensor_model (
    input  wire logic       sys_clk,   // system clock
    input  wire logic       step,      // advance one quadrature count
    input  wire logic       z_req,     // raise the index line
    input  wire logic [2:0] hall_set,  // hall code to present
    output logic            enc_a,     // channel a
    output logic            enc_b,     // channel b
    output logic            enc_z,     // index
    output logic      [2:0] hall       // hall lines
);
    logic [1:0] ph_reg = 2'b00;

    always_ff @(posedge sys_clk)
    begin
        if (step)
            ph_reg <= ph_reg + 2'd1;
    end
    // gray decode so only one channel moves per count, as a healthy encoder does
    assign enc_a = ph_reg[1];
    assign enc_b = ph_reg[1] ^ ph_reg[0];
    assign enc_z = z_req;
    assign hall  = hall_set;
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the servo fault detector
`timescale 1ns/1ps
module testbench;
    import sfd_pkg::*;
    logic        sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        step = 1'b0, z_req = 1'b0, cur_sensor_fail = 1'b0, cur_valid = 1'b0, pl_echo_valid = 1'b0;
    logic        nvm_rd_done = 1'b0, nvm_rd_err = 1'b0, pready, pslverr, irq, fault_active, err, ce = 1'b1;
    logic        enc_a_in, enc_b_in, enc_z_in;
    logic [7:0]  paddr = 8'h00, fault_code_out;
    logic [2:0]  hall_in, hall_set = 3'h1, enc_sector = 3'h7;
    logic [15:0] cur_sample = 16'h0000, drive_temperature_value = 16'h0000, v;
    logic [31:0] pwdata = 32'h0, prdata, pl_echo = 32'h0, rd, rnd = 32'hC992;
    int          miscompares = 0, n_compared = 0, cycles = 0, cnt;

    sfd_top #(.ENC_TIMEOUT(50)) dut (.sys_clk, .resetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .hall_in, .enc_a_in, .enc_b_in, .enc_z_in, .cur_sensor_fail, .cur_sample,
        .cur_valid, .nvm_rd_done, .nvm_rd_err, .pl_echo, .pl_echo_valid, .enc_sector, .drive_temperature_value,
        .irq, .fault_code_out, .fault_active);
    sfd_sensor_model model (.sys_clk, .step, .z_req, .hall_set, .enc_a(enc_a_in), .enc_b(enc_b_in),
        .enc_z(enc_z_in), .hall(hall_in));

    always #2.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // the slave answers after a fixed wait; the master waits for pready and checks that it came after two cycles
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int waits = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no local limit: if pready never comes, only the bench timeout ends this wait
        do
        begin
            @(posedge sys_clk);
            waits++;
        end
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        check("apb wait", waits, 32'd2);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic st(input string what, input logic [31:0] exp);
        tick(4);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(what, rd, exp);
    endtask
    task automatic cur(input logic [15:0] s);
        @(posedge sys_clk);
        cur_sample <= s;
        cur_valid  <= 1'b1;
        @(posedge sys_clk);
        cur_valid  <= 1'b0;
    endtask
    task automatic steps(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            step <= 1'b1;
            @(posedge sys_clk);
            step <= 1'b0;
            tick(2);
        end
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            close_out;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(2);
        resetn <= 1'b1;
        tick(3);
        apb(1'b0, OFS_THRESH, 32'h0);
        check("thresh rst", rd, {16'h0, THRESH_RST});
        apb(1'b0, 8'hFC, 32'h0);
        check("unmapped", {rd[30:0], err}, 32'h1);
        $display("test registers done");
        apb(1'b1, OFS_INTMASK, 32'h7FE);
        @(posedge sys_clk) cur_sensor_fail <= 1'b1;
        @(posedge sys_clk) cur_sensor_fail <= 1'b0;
        tick(2);
        check("irq masked", irq, 1'b0);
        apb(1'b1, OFS_INTMASK, 32'h7FF);
        tick(2);
        check("irq", irq, 1'b1);
        check("code pin", {fault_active, fault_code_out}, 32'h168);
        // a clean read must not count, only the errored one
        @(posedge sys_clk) nvm_rd_done <= 1'b1;
        @(posedge sys_clk) nvm_rd_err <= 1'b1;
        @(posedge sys_clk) nvm_rd_done <= 1'b0;
        nvm_rd_err <= 1'b0;
        st("st 104 106", 32'h005);
        tick(1);
        check("irq clr", irq, 1'b0);
        apb(1'b0, OFS_CODE, 32'h0);
        check("code held", rd, 32'h168);
        apb(1'b1, OFS_CODE, 32'h0);
        tick(1);
        check("code clr", fault_active, 1'b0);
        // an event while the clock enable is low must leave no trace
        @(posedge sys_clk) ce <= 1'b0;
        cur_sensor_fail <= 1'b1;
        tick(2);
        cur_sensor_fail <= 1'b0;
        ce <= 1'b1;
        st("frozen", 32'h0);
        rnd = lfsr(rnd);
        apb(1'b1, OFS_LINK_WR, rnd);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge sys_clk) pl_echo <= rnd ^ i;
            pl_echo_valid <= 1'b1;
            @(posedge sys_clk) pl_echo_valid <= 1'b0;
            st("echo", i ? 32'h010 : 32'h0);
        end
        v = rnd[27:16] + 16'h0001;
        apb(1'b1, OFS_THRESH, {16'h0, v});
        for (int i = 0; i < 2; i++)
        begin
            @(posedge sys_clk) drive_temperature_value <= v + i;
            tick(3);
            drive_temperature_value <= 16'h0;
            st("hot", i ? 32'h400 : 32'h0);
        end
        $display("test events done");
        for (int m = 0; m < 2; m++)
        begin
            rnd = lfsr(rnd);
            v = rnd[11:0] + 16'h0100;
            apb(1'b1, OFS_SHIELD, m ? 32'h8 : 32'h0);
            cur(v);
            cur(v + (v >> 1) - 16'h1);
            cur(v);
            cur(v + ((v + 16'h1) >> 1));
            st("step", m ? 32'h0 : 32'h020);
        end
        for (int d = 0; d < 2; d++)
        begin
            cur(16'd100);
            apb(1'b1, OFS_CTRL, d ? 32'hA : 32'h2);
            cur(d ? 16'd90 : 16'd110);
            cur(d ? 16'd95 : 16'd105);
            apb(1'b1, OFS_CTRL, 32'h0);
            st("winding", 32'h040);
        end
        // hall-to-sector mapping is the design's own; only the count of far sectors is fixed
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, OFS_SHIELD, m ? 32'h4 : 32'h0);
            apb(1'b1, OFS_CTRL, 32'h1);
            cnt = 0;
            for (int s = 0; s < 6; s++)
            begin
                enc_sector <= 3'(s);
                apb(1'b0, OFS_STATUS, 32'h0);
                apb(1'b0, OFS_STATUS, 32'h0);
                cnt += int'(rd[3] === 1'b1);
            end
            check("phase far", cnt, m ? 0 : 3);
            // the watchdog needs a full quiet period before it fires
            tick(50);
            apb(1'b0, OFS_STATUS, 32'h0);
            check("no edges", rd[1], 1'b1);
            enc_sector <= 3'h7;
            apb(1'b1, OFS_CTRL, 32'h0);
            tick(4);
            apb(1'b0, OFS_STATUS, 32'h0);
            check("phase idle", rd[3], 1'b0);
        end
        $display("test monitors done");
        apb(1'b1, OFS_ENC_RES, 32'h8);
        apb(1'b1, OFS_CTRL, 32'h4);
        steps(9);
        @(posedge sys_clk) z_req <= 1'b1;
        tick(3);
        z_req <= 1'b0;
        st("z beyond", 32'h100);
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h4);
        steps(16);
        st("no z edge", 32'h0);
        steps(1);
        st("no z", 32'h080);
        for (int h = 0; h < 2; h++)
        begin
            apb(1'b1, OFS_CTRL, 32'h0);
            apb(1'b1, OFS_CTRL, 32'h4);
            @(posedge sys_clk) hall_set <= h ? 3'h7 : 3'h0;
            tick(4);
            hall_set <= 3'h1;
            st("hall", 32'h200);
        end
        $display("test learning done");
        close_out;
    end
endmodule
